// ===== pulse_period_pkg.sv
// constants for the pulse period measurement timer
package pulse_period_pkg;
   localparam int unsigned ADDR_W = 3;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned CNT_W  = 16;
   // register offsets
   localparam logic [2:0] OFS_CTRL     = 3'h0;
   localparam logic [2:0] OFS_IOC      = 3'h1;
   localparam logic [2:0] OFS_MODE     = 3'h2;
   localparam logic [2:0] OFS_CNT_LO   = 3'h3;
   localparam logic [2:0] OFS_CNT_HI   = 3'h4;
   localparam logic [2:0] OFS_IRQ_STAT = 3'h5;
   localparam logic [2:0] OFS_IRQ_MASK = 3'h6;
   // timer_control fields
   localparam int unsigned CTRL_START_B = 0;
   localparam int unsigned CTRL_RUN_B   = 1;
   localparam int unsigned CTRL_STOP_B  = 2;
   localparam int unsigned CTRL_EDGE_B  = 4;
   localparam int unsigned CTRL_UNF_B   = 5;
   // timer_io_control fields
   localparam int unsigned IOC_POL_B    = 0;
   localparam int unsigned IOC_FILT_LO  = 4;
   localparam int unsigned IOC_FILT_HI  = 5;
   // mode register fields
   localparam int unsigned MODE_LO      = 0;
   localparam int unsigned MODE_HI      = 2;
   localparam logic [2:0]  MODE_PERIOD  = 3'h4;
   // interrupt status / mask bits
   localparam int unsigned IRQ_EDGE_B   = 0;
   localparam int unsigned IRQ_UNF_B    = 1;
   // reset values
   localparam logic [7:0]  CTRL_RST     = 8'h00;
   localparam logic [7:0]  IOC_RST      = 8'h00;
   localparam logic [7:0]  MODE_RST     = 8'h00;
   localparam logic [15:0] RELOAD_RST   = 16'hFFFF;
   localparam logic [1:0]  IRQ_RST      = 2'h0;
   // filter stable-sample counts for select codes 01, 10, 11
   localparam logic [5:0]  FILT_LEN_1   = 6'h03;
   localparam logic [5:0]  FILT_LEN_2   = 6'h08;
   localparam logic [5:0]  FILT_LEN_3   = 6'h20;
endpackage

// ===== pulse_period_measure_timer.sv
// 16-bit timer channel measuring the period between active edges of an input
//
// Behaviour
// (R1) Control bit 4 is an active-edge flag, 0 meaning no edge since the last clear by writing 0.
// (R2) Control bit 5 is an underflow flag, 0 meaning no underflow, cleared by writing 0.
// (R3) With polarity bit 0 of the io control at 0 the period runs rising edge to rising edge.
// (R4) In this mode software keeps the output control, output enable and event gating bits at 0.
// (R5) Filter select bits 5:4 at 00 pass the measurement input with no filtering.
// (R6) An active edge sets the active-edge flag, ending one measurement period.
// (R7) A counter underflow during measurement sets the underflow flag.
// (R8) The 16-bit counter counts the internal source and takes reload values 0001h to FFFFh.
// (R9) Measurement runs only while the three-bit mode field holds 100.
// (R10) Each active edge captures the elapsed count for reading and restarts from the reload.
`timescale 1ns/1ps
module pulse_period_measure_timer (
   // clock and reset
   input  wire logic                            I_SYS_CLK,
   input  wire logic                            I_RESET_N,
   // register port
   input  wire logic [pulse_period_pkg::ADDR_W-1:0] I_ADDR,
   input  wire logic [pulse_period_pkg::DATA_W-1:0] I_WDATA,
   input  wire logic                            I_WR,
   input  wire logic                            I_RD,
   output logic      [pulse_period_pkg::DATA_W-1:0] O_RDATA,
   // measurement input pin
   input  wire logic                            I_MEASURE_INPUT_PIN,
   // interrupt
   output logic                                 O_IRQ
);
   import pulse_period_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // register decode
   logic       wr_ctrl;
   logic       wr_ioc;
   logic       wr_mode;
   logic       wr_lo;
   logic       wr_hi;
   logic       wr_stat;
   logic       wr_mask;
   assign wr_ctrl = I_WR && (I_ADDR == OFS_CTRL);
   assign wr_ioc  = I_WR && (I_ADDR == OFS_IOC);
   assign wr_mode = I_WR && (I_ADDR == OFS_MODE);
   assign wr_lo   = I_WR && (I_ADDR == OFS_CNT_LO);
   assign wr_hi   = I_WR && (I_ADDR == OFS_CNT_HI);
   assign wr_stat = I_WR && (I_ADDR == OFS_IRQ_STAT);
   assign wr_mask = I_WR && (I_ADDR == OFS_IRQ_MASK);

   ////////////////////////////////////////////////////////////////////////////
   // software registers
   logic        start_q;
   logic [7:0]  ioc_q;
   logic [7:0]  mode_q;
   logic [15:0] reload_q;
   logic [7:0]  reload_lo_q;
   logic [1:0]  mask_q;
   logic        force_stop;
   logic        mode_ok;
   logic        run;
   assign force_stop = wr_ctrl && I_WDATA[CTRL_STOP_B];
   assign mode_ok    = (mode_q[MODE_HI:MODE_LO] == MODE_PERIOD); // R9
   assign run        = start_q && mode_ok; // R9

   always_ff @(posedge I_SYS_CLK) begin
      if (!I_RESET_N) begin
         start_q     <= 1'b0;
         ioc_q       <= IOC_RST;
         mode_q      <= MODE_RST;
         reload_q    <= RELOAD_RST;
         reload_lo_q <= 8'h00;
         mask_q      <= IRQ_RST;
      end else begin
         if (force_stop) begin
            start_q <= 1'b0;
         end else if (wr_ctrl) begin
            start_q <= I_WDATA[CTRL_START_B];
         end
         if (wr_ioc) begin
            ioc_q <= I_WDATA;
         end
         if (wr_mode) begin
            mode_q <= I_WDATA;
         end
         if (wr_lo) begin
            reload_lo_q <= I_WDATA;
         end
         // high byte commits the whole reload value
         if (wr_hi) begin
            reload_q <= {I_WDATA, reload_lo_q}; // R8
         end
         if (wr_mask) begin
            mask_q <= I_WDATA[1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // input synchroniser and filter
   logic       sync1_q;
   logic       sync2_q;
   logic       filt_q;
   logic       filt_d;
   logic [5:0] stab_q;
   logic [5:0] stab_d;
   logic [5:0] filt_len;
   logic [1:0] filt_sel;
   assign filt_sel = ioc_q[IOC_FILT_HI:IOC_FILT_LO];
   assign filt_len = (filt_sel == 2'h1) ? FILT_LEN_1 :
                     (filt_sel == 2'h2) ? FILT_LEN_2 : FILT_LEN_3;

   always_comb begin
      stab_d = 6'h00;
      filt_d = filt_q;
      if (filt_sel == 2'h0) begin
         filt_d = sync2_q; // R5
      end else if (sync2_q != filt_q) begin
         stab_d = stab_q + 6'h01;
         if (stab_d >= filt_len) begin
            filt_d = sync2_q;
            stab_d = 6'h00;
         end
      end
   end

   always_ff @(posedge I_SYS_CLK) begin
      if (!I_RESET_N) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         filt_q  <= 1'b0;
         stab_q  <= 6'h00;
      end else begin
         sync1_q <= I_MEASURE_INPUT_PIN;
         sync2_q <= sync1_q;
         filt_q  <= filt_d;
         stab_q  <= stab_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // active edge: rising when polarity bit is 0, falling when 1
   logic filt_prev_q;
   logic edge_act;
   assign edge_act = ioc_q[IOC_POL_B] ? (filt_prev_q && !filt_q)
                                      : (!filt_prev_q && filt_q); // R3

   always_ff @(posedge I_SYS_CLK) begin
      if (!I_RESET_N) begin
         filt_prev_q <= 1'b0;
      end else begin
         filt_prev_q <= filt_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // period counter
   logic [15:0] cnt_q;
   logic [15:0] cnt_d;
   logic [15:0] cap_q;
   logic        edge_ev;
   logic        unf_ev;
   assign edge_ev = run && edge_act; // R6
   assign unf_ev  = run && !edge_act && (cnt_q == 16'h0000); // R7

   always_comb begin
      cnt_d = cnt_q;
      if (!start_q || wr_hi) begin
         cnt_d = wr_hi ? {I_WDATA, reload_lo_q} : reload_q;
      end else if (edge_ev || unf_ev) begin
         cnt_d = reload_q; // R10
      end else if (run) begin
         cnt_d = cnt_q - 16'h0001; // R8
      end
   end

   always_ff @(posedge I_SYS_CLK) begin
      if (!I_RESET_N) begin
         cnt_q <= RELOAD_RST;
         cap_q <= 16'h0000;
      end else begin
         cnt_q <= cnt_d;
         if (edge_ev) begin
            cap_q <= reload_q - cnt_q; // R10
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // flags: hardware set wins over software clear
   logic       edge_flag_q;
   logic       unf_flag_q;
   logic       clr_edge;
   logic       clr_unf;
   logic [1:0] stat_q;
   logic [1:0] stat_set;
   assign clr_edge = wr_ctrl && !I_WDATA[CTRL_EDGE_B]; // R1
   assign clr_unf  = wr_ctrl && !I_WDATA[CTRL_UNF_B]; // R2
   assign stat_set = {unf_ev, edge_ev};

   always_ff @(posedge I_SYS_CLK) begin
      if (!I_RESET_N) begin
         edge_flag_q <= 1'b0;
         unf_flag_q  <= 1'b0;
         stat_q      <= IRQ_RST;
      end else begin
         edge_flag_q <= edge_ev || (edge_flag_q && !clr_edge); // R1 R6
         unf_flag_q  <= unf_ev || (unf_flag_q && !clr_unf); // R2 R7
         stat_q      <= stat_set | (stat_q & ~(wr_stat ? I_WDATA[1:0] : 2'h0));
      end
   end

   assign O_IRQ = |(stat_q & mask_q);

   ////////////////////////////////////////////////////////////////////////////
   // read path
   logic [7:0] ctrl_rd;
   logic [7:0] rd_mux;
   assign ctrl_rd = {2'h0, unf_flag_q, edge_flag_q, 1'b0, 1'b0, run, start_q};
   assign rd_mux  = (I_ADDR == OFS_CTRL)     ? ctrl_rd :
                    (I_ADDR == OFS_IOC)      ? ioc_q :
                    (I_ADDR == OFS_MODE)     ? mode_q :
                    (I_ADDR == OFS_CNT_LO)   ? cap_q[7:0] :
                    (I_ADDR == OFS_CNT_HI)   ? cap_q[15:8] :
                    (I_ADDR == OFS_IRQ_STAT) ? {6'h00, stat_q} :
                    (I_ADDR == OFS_IRQ_MASK) ? {6'h00, mask_q} : 8'h00;

   always_ff @(posedge I_SYS_CLK) begin
      if (!I_RESET_N) begin
         O_RDATA <= 8'h00;
      end else begin
         O_RDATA <= I_RD ? rd_mux : 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // assertions
   sequence s_edge_run;
      run && edge_act;
   endsequence

   sequence s_flag_up;
      edge_flag_q && (cap_q == $past(reload_q) - $past(cnt_q));
   endsequence

   property p_edge_sets;
      @(posedge I_SYS_CLK) disable iff (!I_RESET_N)
      s_edge_run |=> s_flag_up;
   endproperty
   a_edge_sets: assert property (p_edge_sets) // R6
      else $error("edge did not set flag and capture");

   property p_unf_sets;
      @(posedge I_SYS_CLK) disable iff (!I_RESET_N)
      (unf_ev && !wr_hi) |=> (unf_flag_q && cnt_q == $past(reload_q));
   endproperty
   a_unf_sets: assert property (p_unf_sets) // R7
      else $error("underflow did not set flag and reload");

   property p_edge_clear;
      @(posedge I_SYS_CLK) disable iff (!I_RESET_N)
      (clr_edge && !edge_ev) |=> !edge_flag_q;
   endproperty
   a_edge_clear: assert property (p_edge_clear) // R1
      else $error("edge flag not cleared by write of zero");

   property p_unf_hold;
      @(posedge I_SYS_CLK) disable iff (!I_RESET_N)
      (unf_flag_q && !(wr_ctrl && !I_WDATA[CTRL_UNF_B])) |=> unf_flag_q;
   endproperty
   a_unf_hold: assert property (p_unf_hold) // R2
      else $error("underflow flag dropped without a clear");

   property p_no_filter;
      @(posedge I_SYS_CLK) disable iff (!I_RESET_N)
      (filt_sel == 2'h0) |=> (filt_q == $past(sync2_q));
   endproperty
   a_no_filter: assert property (p_no_filter) // R5
      else $error("unfiltered input did not follow synchroniser");

   property p_rise_only;
      @(posedge I_SYS_CLK) disable iff (!I_RESET_N)
      (run && !ioc_q[IOC_POL_B] && filt_prev_q && !filt_q) |=> !$rose(edge_flag_q);
   endproperty
   a_rise_only: assert property (p_rise_only) // R3
      else $error("falling edge taken in rising polarity");

   property p_mode_gate;
      @(posedge I_SYS_CLK) disable iff (!I_RESET_N)
      (!mode_ok && start_q && !wr_mode && !wr_hi) |=> $stable(cnt_q) && !$rose(edge_flag_q);
   endproperty
   a_mode_gate: assert property (p_mode_gate) // R9
      else $error("counter moved outside the period mode");

   property p_count_down;
      @(posedge I_SYS_CLK) disable iff (!I_RESET_N)
      (run && !edge_act && cnt_q != 16'h0000 && !wr_hi && !force_stop)
         |=> (cnt_q == $past(cnt_q) - 16'h0001);
   endproperty
   a_count_down: assert property (p_count_down) // R8
      else $error("counter did not step down by one");

   property p_irq;
      @(posedge I_SYS_CLK) disable iff (!I_RESET_N)
      (edge_ev && mask_q[IRQ_EDGE_B] && !wr_mask) |=> O_IRQ;
   endproperty
   a_irq: assert property (p_irq) // R6
      else $error("unmasked edge did not raise interrupt");

   property p_read;
      @(posedge I_SYS_CLK) disable iff (!I_RESET_N)
      (I_RD && I_ADDR == OFS_CNT_LO) |=> (O_RDATA == $past(cap_q[7:0]));
   endproperty
   a_read: assert property (p_read) // R10
      else $error("captured count not returned on read");
endmodule

// ===== pulse_source.sv
// far-side model: external pulse source driving the measurement input
`timescale 1ns/1ps
module pulse_source (
   // clock
   input  wire logic i_clk,
   // pin
   output logic      o_pin
);
   initial o_pin = 1'b0;
   // n rising edges spaced p cycles apart, high for half of each period
   task automatic train(input int p, input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge i_clk);
         o_pin <= 1'b1;
         repeat (p / 2) @(posedge i_clk);
         o_pin <= 1'b0;
         repeat (p - p / 2 - 1) @(posedge i_clk);
      end
   endtask
   // hold the pin at a fixed level from the next edge on
   task automatic level(input logic v);
      @(posedge i_clk);
      o_pin <= v;
   endtask
endmodule

// ===== tb_pulse_period_measure_timer.sv
// self-checking testbench for the pulse period measurement timer
`timescale 1ns/1ps
module tb_pulse_period_measure_timer;
   import pulse_period_pkg::*;
   logic              clk;
   logic              rst_n;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata;
   logic              wr;
   logic              rd;
   logic [DATA_W-1:0] rdata;
   logic              pin;
   logic              irq;
   logic [DATA_W-1:0] d;
   logic [15:0]       reload;
   logic [15:0]       cap;
   int                error_cnt;
   int                checked;
   int                cyc;
   int                p;
   int                ofs_q[$];

   pulse_period_measure_timer pulse_period_measure_timer_inst (
      .I_SYS_CLK           (clk),
      .I_RESET_N           (rst_n),
      .I_ADDR              (addr),
      .I_WDATA             (wdata),
      .I_WR                (wr),
      .I_RD                (rd),
      .O_RDATA             (rdata),
      .I_MEASURE_INPUT_PIN (pin),
      .O_IRQ               (irq)
   );
   pulse_source pulse_source_inst (
      .i_clk (clk),
      .o_pin (pin)
   );

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic results();
      $display("checks %0d errors %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wreg(input logic [2:0] a, input logic [7:0] v);
      @(posedge clk);
      addr  <= a;
      wdata <= v;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
   endtask
   task automatic rreg(input logic [2:0] a, output logic [7:0] v);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      #1 v = rdata;
   endtask
   task automatic clear_all();
      wreg(OFS_CTRL, 8'h01);
      wreg(OFS_IRQ_STAT, 8'h03);
   endtask

   always @(posedge clk) begin
      cyc++;
      if (cyc == 50000) begin
         error_cnt++;
         results();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   initial begin
      rst_n = 1'b0;
      addr  = '0;
      wdata = '0;
      wr    = 1'b0;
      rd    = 1'b0;
      void'($urandom(64));
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      // reset values and the unmapped address
      ofs_q = '{OFS_CTRL, OFS_IOC, OFS_MODE, OFS_IRQ_STAT, OFS_IRQ_MASK, 3'h7};
      foreach (ofs_q[i]) begin
         rreg(ofs_q[i][2:0], d);
         chk(d, 16'h0000);
      end
      wreg(3'h7, 8'hFF);
      rreg(3'h7, d);
      chk(d, 16'h0000);
      // rising polarity, no filter, output and gating bits kept clear
      wreg(OFS_IOC, 8'h00);
      wreg(OFS_MODE, {5'h00, MODE_PERIOD});
      rreg(OFS_MODE, d);
      chk(d, 16'h0004);
      wreg(OFS_IRQ_MASK, 8'h03);
      reload = 16'h0100 + 16'($urandom % 16'hFE00);
      wreg(OFS_CNT_LO, reload[7:0]);
      wreg(OFS_CNT_HI, reload[15:8]);
      wreg(OFS_CTRL, 8'h01);
      // period measurement over a random period
      p = 20 + int'($urandom % 100);
      pulse_source_inst.train(p, 3);
      repeat (8) @(posedge clk);
      rreg(OFS_CTRL, d);
      chk(d[5:0], 16'h0013);
      chk(irq, 1'b1);
      rreg(OFS_CNT_LO, cap[7:0]);
      rreg(OFS_CNT_HI, cap[15:8]);
      chk(cap >= 16'(p - 1) && cap <= 16'(p + 1), 1'b1);
      // flags cleared by writing zeros, status by writing ones
      clear_all();
      rreg(OFS_CTRL, d);
      chk(d[5:4], 2'b00);
      chk(irq, 1'b0);
      // a falling edge is not active with polarity 0
      pulse_source_inst.level(1'b1);
      repeat (10) @(posedge clk);
      clear_all();
      pulse_source_inst.level(1'b0);
      repeat (10) @(posedge clk);
      rreg(OFS_CTRL, d);
      chk(d[4], 1'b0);
      // short reload with no edges gives underflow
      wreg(OFS_CNT_LO, 8'h10);
      wreg(OFS_CNT_HI, 8'h00);
      repeat (40) @(posedge clk);
      rreg(OFS_CTRL, d);
      chk(d[5:4], 2'b10);
      rreg(OFS_IRQ_STAT, d);
      chk(d[1:0], 2'b10);
      wreg(OFS_IRQ_MASK, 8'h01);
      #1 chk(irq, 1'b0);
      wreg(OFS_IRQ_MASK, 8'h02);
      #1 chk(irq, 1'b1);
      // edges are ignored outside the period mode
      wreg(OFS_MODE, 8'h00);
      clear_all();
      pulse_source_inst.train(20, 2);
      repeat (8) @(posedge clk);
      rreg(OFS_CTRL, d);
      chk(d[5:4], 2'b00);
      // falling polarity with the shortest filter: glitch dropped, only the fall is active
      wreg(OFS_IOC, 8'h11);
      wreg(OFS_MODE, {5'h00, MODE_PERIOD});
      clear_all();
      pulse_source_inst.train(4, 1);
      repeat (10) @(posedge clk);
      rreg(OFS_CTRL, d);
      chk(d[4], 1'b0);
      pulse_source_inst.level(1'b1);
      repeat (10) @(posedge clk);
      rreg(OFS_CTRL, d);
      chk(d[4], 1'b0);
      pulse_source_inst.level(1'b0);
      repeat (10) @(posedge clk);
      rreg(OFS_CTRL, d);
      chk(d[4], 1'b1);
      results();
   end
endmodule
